// ==== core/port_supervisor.sv ====
/*
 One port's disconnect and overcurrent-cut supervision timers.
 Assumes the comparator levels arrive already synchronised to mclk_in.
*/
module port_supervisor
   import pse_cfg_pkg::*;
#(
   parameter int unsigned DISC_CYC = DISC_TIME_CYC,
   parameter int unsigned CUT_CYC  = CUT_TIME_CYC
)
(
   input  wire logic mclk_in,
   input  wire logic sys_rst_in,
   input  wire logic powered_in,
   input  wire logic below_disc_in,
   input  wire logic above_cut_in,
   output logic      disc_off_out,
   output logic      cut_fault_out
);
   logic [31:0] disconnect_timer_ff;
   logic [31:0] cut_fault_timer_ff;

   // Count down from the load value; zero is the terminal count
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in || !powered_in || !below_disc_in)
         disconnect_timer_ff <= DISC_CYC - 1;
      else if (disconnect_timer_ff != 32'h0)
         disconnect_timer_ff <= disconnect_timer_ff - 32'h1;
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in || !powered_in || !above_cut_in)
         cut_fault_timer_ff <= CUT_CYC - 1;
      else if (cut_fault_timer_ff != 32'h0)
         cut_fault_timer_ff <= cut_fault_timer_ff - 32'h1;
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         disc_off_out  <= 1'b0;
         cut_fault_out <= 1'b0;
      end
      else
      begin
         disc_off_out  <= powered_in && below_disc_in &&
                          disconnect_timer_ff == 32'h0;
         cut_fault_out <= powered_in && above_cut_in &&
                          cut_fault_timer_ff == 32'h0;
      end
   end
endmodule

// ==== core/pse_cfg_pkg.sv ====
/*
 Constants for the per-port policy configuration bank: command codes,
 field layouts, reset values and timing. Assumes a 10 MHz core clock.
*/
package pse_cfg_pkg;
   localparam int unsigned NUM_PORTS = 4;
   localparam logic [7:0] CMD_LEGACY_MODE   = 8'h20;
   localparam logic [7:0] CMD_SECOND_CLASS  = 8'h21;
   localparam logic [7:0] CMD_DEFER_TIMER   = 8'h27;
   localparam logic [7:0] CMD_DISCONNECT    = 8'h29;
   localparam logic [7:0] CMD_CUT_P12       = 8'h2a;
   localparam logic [7:0] CMD_CUT_P34       = 8'h2b;
   localparam logic [7:0] CMD_TEMPERATURE   = 8'h2c;
   localparam logic [7:0] RST_LEGACY_MODE   = 8'h00;
   localparam logic [7:0] RST_SECOND_CLASS  = 8'haa;
   localparam logic [7:0] RST_DEFER_TIMER   = 8'h00;
   localparam logic [7:0] RST_DISCONNECT    = 8'h00;
   localparam logic [7:0] RST_CUT           = 8'h00;
   localparam int unsigned CUT_HI_POS       = 4;
   localparam int unsigned DEFER_FIELD_W    = 4;
   localparam logic [1:0] LEG_STANDARD      = 2'h0;
   localparam logic [1:0] LEG_LEGACY_ONLY   = 2'h1;
   localparam logic [1:0] LEG_STD_THEN_LEG  = 2'h2;
   localparam logic [1:0] SECOND_CLASS_OFF  = 2'h0;
   localparam logic [2:0] CLASS_FOUR        = 3'h4;
   localparam int unsigned CLK_HZ           = 10_000_000;
   localparam int unsigned DEFER_STEP_MS    = 10;
   localparam int unsigned DEFER_STEP_CYC   = CLK_HZ / 1000 * DEFER_STEP_MS;
   localparam int unsigned DISC_TIME_MS     = 300;
   localparam int unsigned DISC_TIME_CYC    = CLK_HZ / 1000 * DISC_TIME_MS;
   localparam int unsigned CUT_TIME_MS      = 60;
   localparam int unsigned CUT_TIME_CYC     = CLK_HZ / 1000 * CUT_TIME_MS;
   typedef enum logic [1:0] {
      MODE_OFF,
      MODE_MANUAL,
      MODE_SEMI_AUTO,
      MODE_AUTO
   } op_mode_t;
   typedef enum logic [1:0] {
      SEQ_NONE,
      SEQ_STANDARD,
      SEQ_LEGACY,
      SEQ_STD_THEN_LEG
   } detect_seq_t;
endpackage

// ==== core/pse_port_policy_config_bank.sv ====
/*
 Per-port policy configuration bank of a four-port power-sourcing
 controller: command-coded byte registers, detect and second-class
 sequence selection, interrupt deferral and port supervision.
 Assumes an upstream serial slave decodes each transfer into one command
 code plus one data byte, and that analog comparators and the
 temperature converter sit outside. Comparator levels are synchronised here; other pin-level inputs are not.
*/
// How it works
// - Legacy code 00 with detect enabled runs standard detection only.
// - Legacy code 01 with detect enabled runs legacy detection only.
// - Code 10 runs standard then legacy; code 11 reserved, treated as none.
// - Legacy detect starts on restart button, or detect enable in auto modes.
// - Legacy result never auto-powers a port; host must power it on.
// - Second-class code 00 disables the second classification event.
// - Codes 01 and 11 add a second event after class 4; 10 reserved.
// - Second event gating differs by manual, semi-auto and auto mode.
// - Non-zero defer period N gives a free-running period of N times 10 ms.
// - Pending non-critical interrupts pass only when the timer hits zero.
// - Defer period zero passes every interrupt immediately.
// - Reading the defer register returns the last written value.
// - Disconnect, cut and legacy fields are held separately per port.
// - Powered port below disconnect threshold starts timer; expiry powers off.
// - Disconnect codes select 7.5, 15, 30 and 50 milliamps.
// - Three-bit cut code per port; ports 1,2 at 2Ah and 3,4 at 2Bh.
// - Current above cut starts cut timer; terminal zero declares a fault.
// - Cut codes map to 374,110,204,374,754,592,645,920 milliamps.
// - Temperature register is a read-only 8-bit conversion result.
// - Each register is one command code followed by one data byte.
module pse_port_policy_config_bank
   import pse_cfg_pkg::*;
#(
   parameter int unsigned DEFER_STEP = DEFER_STEP_CYC,
   parameter int unsigned DISC_CYC   = DISC_TIME_CYC,
   parameter int unsigned CUT_CYC    = CUT_TIME_CYC
)
(
   input  wire logic                     mclk_in,
   input  wire logic                     sys_rst_in,
   input  wire logic                     cmd_wr_in,
   input  wire logic                     cmd_rd_in,
   input  wire logic [7:0]               cmd_code_in,
   input  wire logic [7:0]               cmd_data_in,
   input  wire pse_cfg_pkg::op_mode_t    op_mode_in,
   input  wire logic [3:0]               port_detect_enable_in,
   input  wire logic [3:0]               port_class_enable_in,
   input  wire logic [3:0]               port_detect_restart_button_in,
   input  wire logic [3:0]               port_class_restart_button_in,
   input  wire logic [3:0]               port_power_on_button_in,
   input  wire logic [3:0]               port_powered_in,
   input  wire logic [3:0]               first_class_done_in,
   input  wire logic [11:0]              first_class_result_in,
   input  wire logic [3:0]               port_below_disc_in,
   input  wire logic [3:0]               port_above_cut_in,
   input  wire logic                     temp_valid_in,
   input  wire logic [7:0]               temp_code_in,
   input  wire logic [7:0]               irq_noncrit_in,
   input  wire logic [7:0]               irq_crit_in,
   output logic [7:0]                    rd_data_out,
   output logic                          rd_valid_out,
   output logic [7:0]                    detect_seq_out,
   output logic [3:0]                    legacy_power_hold_out,
   output logic [3:0]                    second_class_go_out,
   output logic [7:0]                    disconnect_code_out,
   output logic [11:0]                   overcurrent_cut_code_out,
   output logic [3:0]                    disconnect_off_out,
   output logic [3:0]                    cut_fault_out,
   output logic [7:0]                    irq_forward_out
);
   logic [7:0]  legacy_detect_mode_ff;
   logic [7:0]  two_event_class_ctrl_ff;
   logic [7:0]  interrupt_defer_timer_ff;
   logic [7:0]  disconnect_threshold_ff;
   logic [7:0]  overcurrent_cut_ports_1_2_ff;
   logic [7:0]  overcurrent_cut_ports_3_4_ff;
   logic [7:0]  die_temperature_ff;
   logic [3:0]  below_s1_ff;
   logic [3:0]  below_s2_ff;
   logic [3:0]  above_s1_ff;
   logic [3:0]  above_s2_ff;
   logic [31:0] step_cnt_ff;
   logic [3:0]  period_cnt_ff;
   logic [7:0]  pending_ff;
   logic        defer_tick;
   logic [DEFER_FIELD_W-1:0] irq_defer_period;
   logic [3:0]  disc_off;
   logic [3:0]  cut_fault;

   assign irq_defer_period =
      interrupt_defer_timer_ff[DEFER_FIELD_W-1:0];

   // Whole-byte command registers; the read-only code ignores writes
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         legacy_detect_mode_ff        <= RST_LEGACY_MODE;
         two_event_class_ctrl_ff      <= RST_SECOND_CLASS;
         interrupt_defer_timer_ff     <= RST_DEFER_TIMER;
         disconnect_threshold_ff      <= RST_DISCONNECT;
         overcurrent_cut_ports_1_2_ff <= RST_CUT;
         overcurrent_cut_ports_3_4_ff <= RST_CUT;
      end
      else if (cmd_wr_in)
      begin
         unique case (cmd_code_in)
            CMD_LEGACY_MODE:  legacy_detect_mode_ff <= cmd_data_in;
            CMD_SECOND_CLASS: two_event_class_ctrl_ff <= cmd_data_in;
            // Upper bits stored as written; host keeps them at reset
            CMD_DEFER_TIMER:  interrupt_defer_timer_ff <= cmd_data_in;
            CMD_DISCONNECT:   disconnect_threshold_ff <= cmd_data_in;
            CMD_CUT_P12:      overcurrent_cut_ports_1_2_ff <= cmd_data_in;
            CMD_CUT_P34:      overcurrent_cut_ports_3_4_ff <= cmd_data_in;
            default:          ;
         endcase
      end
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         die_temperature_ff <= 8'h00;
      else if (temp_valid_in)
         die_temperature_ff <= temp_code_in;
   end

   // Read answers one cycle after the request; unmapped codes give zero
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         rd_data_out  <= 8'h00;
         rd_valid_out <= 1'b0;
      end
      else
      begin
         rd_valid_out <= cmd_rd_in;
         if (cmd_rd_in)
         begin
            unique case (cmd_code_in)
               CMD_LEGACY_MODE:  rd_data_out <= legacy_detect_mode_ff;
               CMD_SECOND_CLASS: rd_data_out <= two_event_class_ctrl_ff;
               CMD_DEFER_TIMER:  rd_data_out <= interrupt_defer_timer_ff;
               CMD_DISCONNECT:   rd_data_out <= disconnect_threshold_ff;
               CMD_CUT_P12:      rd_data_out <= overcurrent_cut_ports_1_2_ff;
               CMD_CUT_P34:      rd_data_out <= overcurrent_cut_ports_3_4_ff;
               CMD_TEMPERATURE:  rd_data_out <= die_temperature_ff;
               default:          rd_data_out <= 8'h00;
            endcase
         end
      end
   end

   // Comparator levels come from the analog side, asynchronous to us
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         below_s1_ff <= 4'h0;
         below_s2_ff <= 4'h0;
         above_s1_ff <= 4'h0;
         above_s2_ff <= 4'h0;
      end
      else
      begin
         below_s1_ff <= port_below_disc_in;
         below_s2_ff <= below_s1_ff;
         above_s1_ff <= port_above_cut_in;
         above_s2_ff <= above_s1_ff;
      end
   end

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++)
      begin : g_port
         logic [1:0] port_legacy_mode_field;
         logic [1:0] port_second_class_field;
         logic [2:0] port_overcurrent_cut_code;
         logic       detect_trigger;
         logic       second_gate;
         detect_seq_t seq;

         assign port_legacy_mode_field  = legacy_detect_mode_ff[2*p +: 2];
         assign port_second_class_field = two_event_class_ctrl_ff[2*p +: 2];
         assign port_overcurrent_cut_code = (p < 2) ?
            overcurrent_cut_ports_1_2_ff[CUT_HI_POS*(p%2) +: 3] :
            overcurrent_cut_ports_3_4_ff[CUT_HI_POS*(p%2) +: 3];

         // Restart button in any mode; enable level in the automatic modes
         assign detect_trigger = port_detect_restart_button_in[p] ||
            (port_detect_enable_in[p] &&
             (op_mode_in == MODE_SEMI_AUTO || op_mode_in == MODE_AUTO));

         always_comb
         begin
            seq = SEQ_NONE;
            if (detect_trigger)
            begin
               unique case (port_legacy_mode_field)
                  LEG_STANDARD:     seq = SEQ_STANDARD;
                  LEG_LEGACY_ONLY:  seq = SEQ_LEGACY;
                  LEG_STD_THEN_LEG: seq = SEQ_STD_THEN_LEG;
                  default:          seq = SEQ_NONE;
               endcase
            end
         end

         always_comb
         begin
            unique case (op_mode_in)
               MODE_MANUAL:    second_gate = port_class_enable_in[p] ||
                                  port_class_restart_button_in[p];
               MODE_SEMI_AUTO: second_gate = port_class_enable_in[p] ||
                                  port_power_on_button_in[p];
               MODE_AUTO:      second_gate = 1'b1;
               MODE_OFF:       second_gate = 1'b0;
            endcase
         end

         always_ff @(posedge mclk_in)
         begin
            if (sys_rst_in)
            begin
               detect_seq_out[2*p +: 2]        <= SEQ_NONE;
               legacy_power_hold_out[p]        <= 1'b0;
               second_class_go_out[p]          <= 1'b0;
               disconnect_code_out[2*p +: 2]   <= 2'h0;
               overcurrent_cut_code_out[3*p +: 3] <= 3'h0;
            end
            else
            begin
               detect_seq_out[2*p +: 2] <= seq;
               // Automatic power-up is blocked in semi-auto and auto modes whenever the legacy field is not standard
               legacy_power_hold_out[p] <=
                  (op_mode_in == MODE_SEMI_AUTO || op_mode_in == MODE_AUTO)
                  && port_legacy_mode_field != LEG_STANDARD;
               second_class_go_out[p] <= first_class_done_in[p] &&
                  first_class_result_in[3*p +: 3] == CLASS_FOUR &&
                  port_second_class_field[0] && second_gate;
               disconnect_code_out[2*p +: 2] <=
                  disconnect_threshold_ff[2*p +: 2];
               overcurrent_cut_code_out[3*p +: 3] <=
                  port_overcurrent_cut_code;
            end
         end

         port_supervisor #(
            .DISC_CYC (DISC_CYC),
            .CUT_CYC  (CUT_CYC)
         ) u_sup (
            .mclk_in       (mclk_in),
            .sys_rst_in    (sys_rst_in),
            .powered_in    (port_powered_in[p]),
            .below_disc_in (below_s2_ff[p]),
            .above_cut_in  (above_s2_ff[p]),
            .disc_off_out  (disc_off[p]),
            .cut_fault_out (cut_fault[p])
         );
      end
   endgenerate

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
      begin
         disconnect_off_out <= 4'h0;
         cut_fault_out      <= 4'h0;
      end
      else
      begin
         disconnect_off_out <= disc_off;
         cut_fault_out      <= cut_fault;
      end
   end

   // Free-running deferral: a step prescaler feeding a period counter
   assign defer_tick = irq_defer_period != 4'h0 &&
                       step_cnt_ff == 32'h0 && period_cnt_ff == 4'h1;

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in || irq_defer_period == 4'h0)
      begin
         step_cnt_ff   <= DEFER_STEP - 1;
         period_cnt_ff <= 4'h0;
      end
      // Load N once on enable so the first period is N steps, not N+1
      else if (period_cnt_ff == 4'h0)
         period_cnt_ff <= irq_defer_period;
      else if (step_cnt_ff != 32'h0)
         step_cnt_ff <= step_cnt_ff - 32'h1;
      else
      begin
         step_cnt_ff <= DEFER_STEP - 1;
         // Reload at one, on the last step, and keep counting
         period_cnt_ff <= (period_cnt_ff <= 4'h1) ?
                          irq_defer_period : period_cnt_ff - 4'h1;
      end
   end

   // New events in the release cycle stay pending, never lost
   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         pending_ff <= 8'h00;
      else if (irq_defer_period == 4'h0 || defer_tick)
         pending_ff <= defer_tick ? irq_noncrit_in : 8'h00;
      else
         pending_ff <= pending_ff | irq_noncrit_in;
   end

   always_ff @(posedge mclk_in)
   begin
      if (sys_rst_in)
         irq_forward_out <= 8'h00;
      else if (irq_defer_period == 4'h0)
         irq_forward_out <= irq_noncrit_in | irq_crit_in;
      else
         irq_forward_out <= irq_crit_in |
                            (defer_tick ? pending_ff : 8'h00);
   end

   a_read_defer_back: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      cmd_wr_in && cmd_code_in == CMD_DEFER_TIMER ##1 !cmd_wr_in ##1
      cmd_rd_in && cmd_code_in == CMD_DEFER_TIMER && !cmd_wr_in
      |=> rd_data_out == $past(cmd_data_in, 3))
      else $error("defer read differs from last write");
   a_immediate_irq: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      irq_defer_period == 4'h0 && !cmd_wr_in
      |=> irq_forward_out == $past(irq_noncrit_in | irq_crit_in))
      else $error("irq not passed at once");
   a_defer_hold: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      irq_defer_period != 4'h0 && !defer_tick && irq_crit_in == 8'h00
      |=> irq_forward_out == 8'h00)
      else $error("deferred irq leaked early");
   a_legacy_only: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      port_detect_restart_button_in[0] &&
      legacy_detect_mode_ff[1:0] == LEG_LEGACY_ONLY
      |=> detect_seq_out[1:0] == SEQ_LEGACY)
      else $error("legacy-only sequence not chosen");
   a_std_detect: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      port_detect_restart_button_in[1] &&
      legacy_detect_mode_ff[3:2] == LEG_STANDARD
      |=> detect_seq_out[3:2] == SEQ_STANDARD)
      else $error("standard sequence not chosen");
   a_second_off: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      two_event_class_ctrl_ff[1:0] == SECOND_CLASS_OFF
      |=> !second_class_go_out[0])
      else $error("second class with field off");
   a_second_auto: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      op_mode_in == MODE_AUTO && first_class_done_in[0] &&
      first_class_result_in[2:0] == CLASS_FOUR &&
      two_event_class_ctrl_ff[1:0] == 2'h3
      |=> second_class_go_out[0])
      else $error("second class missed in auto");
   a_cut_map: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      ##1 overcurrent_cut_code_out[11:9] ==
      $past(overcurrent_cut_ports_3_4_ff[6:4]))
      else $error("port 4 cut code misplaced");
   a_temp_ro: assert property (@(posedge mclk_in)
      disable iff (sys_rst_in)
      !temp_valid_in |=> $stable(die_temperature_ff))
      else $error("temperature changed without conversion");
   c_defer_tick: cover property (@(posedge mclk_in) defer_tick);
   c_second_go: cover property (@(posedge mclk_in)
      second_class_go_out != 4'h0);
   c_cut_fault: cover property (@(posedge mclk_in) cut_fault_out != 4'h0);
endmodule

// ==== verif/host_cmd_master.sv ====
/*
 Host-side command master for the policy bank: one command code and one
 data byte per transfer, driven on the falling edge of mclk_in.
 Assumes the bench supplies mclk_in and calls the two tasks in turn.
*/
module host_cmd_master
(
   input  wire logic       mclk_in,
   input  wire logic       rd_valid_in,
   input  wire logic [7:0] rd_data_in,
   output logic            cmd_wr_out,
   output logic            cmd_rd_out,
   output logic [7:0]      cmd_code_out,
   output logic [7:0]      cmd_data_out
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      cmd_wr_out = 1'b0;
      cmd_rd_out = 1'b0;
      cmd_code_out = 8'h5a;
      cmd_data_out = 8'ha5;
   end

   // Idle lines show the inverse of the last byte, never a stale copy
   task automatic write_reg(input logic [7:0] c, input logic [7:0] d);
      @(negedge mclk_in);
      cmd_code_out = c;
      cmd_data_out = (c == 8'h27) ? {4'h0, d[3:0]} : d;
      cmd_wr_out = 1'b1;
      @(negedge mclk_in);
      cmd_wr_out = 1'b0;
      cmd_code_out = ~cmd_code_out;
      cmd_data_out = ~cmd_data_out;
   endtask

   task automatic read_reg(input logic [7:0] c, output logic [7:0] d);
      int n;
      @(negedge mclk_in);
      cmd_code_out = c;
      cmd_rd_out = 1'b1;
      @(negedge mclk_in);
      n = 0;
      while (rd_valid_in !== 1'b1 && n < 4)
      begin
         @(negedge mclk_in);
         n++;
      end
      d = (n < 4) ? rd_data_in : 8'hxx;
      cmd_rd_out = 1'b0;
      cmd_code_out = ~cmd_code_out;
   endtask
endmodule

// ==== verif/pse_port_policy_config_bank_tb.sv ====
/*
 Self-checking bench for the policy bank: a reference model of the byte
 registers and per-port outputs, compared with the design at every result.
 Assumes host_cmd_master as the command source; timers are shortened.
*/
module pse_port_policy_config_bank_tb;
   import pse_cfg_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int STEP = 4;
   localparam int DCYC = 8;
   localparam int CCYC = 8;
   logic        mclk_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        wr, rd, rd_valid, temp_valid;
   logic [7:0]  code, data, rd_data, seq, disc_code, nc, cr, fwd, temp;
   logic [3:0]  det_en, cl_en, btn, powered, below, above, class_done;
   logic [3:0]  hold, go, disc_off, cut_flt;
   logic [11:0] class_res, cut_code;
   op_mode_t    mode;
   logic [7:0]  m [logic [7:0]];
   logic [31:0] seed = 32'h6975e770;
   int          n_errors = 0;
   int          checked = 0;

   always #50 mclk_in = ~mclk_in;

   host_cmd_master host_cmd_master_inst (.mclk_in(mclk_in),
      .rd_valid_in(rd_valid), .rd_data_in(rd_data), .cmd_wr_out(wr),
      .cmd_rd_out(rd), .cmd_code_out(code), .cmd_data_out(data));

   pse_port_policy_config_bank #(.DEFER_STEP(STEP), .DISC_CYC(DCYC),
      .CUT_CYC(CCYC)) pse_port_policy_config_bank_inst (
      .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .cmd_wr_in(wr),
      .cmd_rd_in(rd), .cmd_code_in(code), .cmd_data_in(data),
      .op_mode_in(mode), .port_detect_enable_in(det_en),
      .port_class_enable_in(cl_en), .port_detect_restart_button_in(btn),
      .port_class_restart_button_in(btn), .port_power_on_button_in(btn),
      .port_powered_in(powered), .first_class_done_in(class_done),
      .first_class_result_in(class_res), .port_below_disc_in(below),
      .port_above_cut_in(above), .temp_valid_in(temp_valid),
      .temp_code_in(temp), .irq_noncrit_in(nc), .irq_crit_in(cr),
      .rd_data_out(rd_data), .rd_valid_out(rd_valid),
      .detect_seq_out(seq), .legacy_power_hold_out(hold),
      .second_class_go_out(go), .disconnect_code_out(disc_code),
      .overcurrent_cut_code_out(cut_code), .disconnect_off_out(disc_off),
      .cut_fault_out(cut_flt), .irq_forward_out(fwd));

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [11:0] exp_det();
      logic [1:0]  c;
      logic [11:0] e;
      e = '0;
      for (int p = 0; p < 4; p++)
      begin
         c = m[CMD_LEGACY_MODE][2*p +: 2];
         e[2*p +: 2] = (c == 2'h3) ? 2'h0 : c + 2'h1;
         e[8 + p] = (c != 2'h0);
      end
      return e;
   endfunction

   function automatic logic [7:0] pick(int s);
      case (s)
         0: return fwd;
         1: return {4'h0, go};
         default: return {cut_flt, disc_off};
      endcase
   endfunction

   task automatic chk(input string what, input logic [11:0] exp,
                      input logic [11:0] got);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr_m(input logic [7:0] c, input logic [7:0] d);
      host_cmd_master_inst.write_reg(c, d);
      if (c != CMD_TEMPERATURE && m.exists(c))
         m[c] = (c == CMD_DEFER_TIMER) ? {4'h0, d[3:0]} : d;
   endtask

   task automatic rd_chk(input logic [7:0] c);
      logic [7:0] d;
      host_cmd_master_inst.read_reg(c, d);
      chk("read", {4'h0, m.exists(c) ? m[c] : 8'h00}, {4'h0, d});
   endtask

   // Clears every one-cycle pulse input at the first falling edge
   task automatic watch(input int n, input int s, output logic [11:0] acc,
                        output int first);
      logic [7:0] v;
      acc = '0;
      first = -1;
      for (int i = 0; i < n; i++)
      begin
         @(negedge mclk_in);
         if (i == 0)
            {nc, cr, temp_valid, class_done, btn} = '0;
         v = pick(s);
         acc = acc | {4'h0, v};
         if (v != 8'h00 && first < 0)
            first = i;
      end
   endtask

   task automatic wrap_up();
      $display("checked %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      #(100 * 5000);
      n_errors++;
      wrap_up();
   end

   initial
   begin
      logic [11:0] acc;
      logic [31:0] r;
      logic [7:0]  v;
      logic [7:0]  rw [6];
      int          first;
      rw = '{8'h20, 8'h21, 8'h27, 8'h29, 8'h2a, 8'h2b};
      {temp_valid, class_done, nc, cr, temp, class_res} = '0;
      {btn, powered, below, above, cl_en} = '0;
      det_en = 4'hf;
      mode = MODE_AUTO;
      m[CMD_LEGACY_MODE] = RST_LEGACY_MODE;
      m[CMD_SECOND_CLASS] = RST_SECOND_CLASS;
      m[CMD_DEFER_TIMER] = RST_DEFER_TIMER;
      m[CMD_DISCONNECT] = RST_DISCONNECT;
      m[CMD_CUT_P12] = RST_CUT;
      m[CMD_CUT_P34] = RST_CUT;
      m[CMD_TEMPERATURE] = 8'h00;
      repeat (5) @(negedge mclk_in);
      sys_rst_in = 1'b0;
      foreach (m[c])
         rd_chk(c);
      rd_chk(8'h30);
      $display("test reset_values done");
      for (int i = 0; i < 24; i++)
      begin
         r = rnd();
         wr_m(rw[i % 6], r[7:0]);
         rd_chk(rw[i % 6]);
      end
      wr_m(8'h31, r[15:8]);
      rd_chk(8'h31);
      wr_m(CMD_TEMPERATURE, r[23:16]);
      rd_chk(CMD_TEMPERATURE);
      @(negedge mclk_in);
      temp = r[31:24];
      temp_valid = 1'b1;
      watch(1, 0, acc, first);
      m[CMD_TEMPERATURE] = r[31:24];
      rd_chk(CMD_TEMPERATURE);
      chk("disc_code", {4'h0, m[CMD_DISCONNECT]}, {4'h0, disc_code});
      chk("cut_code", {m[CMD_CUT_P34][6:4], m[CMD_CUT_P34][2:0],
          m[CMD_CUT_P12][6:4], m[CMD_CUT_P12][2:0]}, cut_code);
      $display("test registers done");
      for (int c = 0; c < 4; c++)
      begin
         for (int p = 0; p < 4; p++)
            v[2*p +: 2] = 2'(c + p);
         wr_m(CMD_LEGACY_MODE, v);
         btn = 4'hf;
         watch(3, 0, acc, first);
         chk("detect", exp_det(), {hold, seq});
      end
      $display("test detect_modes done");
      for (int c = 0; c < 16; c++)
      begin
         r = rnd();
         wr_m(CMD_SECOND_CLASS, {4{c[1:0]}});
         @(negedge mclk_in);
         mode = op_mode_t'(c[3:2]);
         cl_en = r[3:0];
         btn = r[7:4];
         class_res = r[8] ? 12'h924 : 12'h6db;
         class_done = 4'hf;
         v = (mode == MODE_AUTO) ? 8'h0f : (mode == MODE_OFF) ? 8'h00 :
             {4'h0, r[3:0] | r[7:4]};
         watch(4, 1, acc, first);
         chk("second_class", (r[8] && c[0]) ? {4'h0, v} : 12'h0,
             acc);
      end
      mode = MODE_AUTO;
      $display("test second_class done");
      for (int t = 0; t < 3; t += 2)
      begin
         r = rnd();
         wr_m(CMD_DEFER_TIMER, 8'(t));
         @(negedge mclk_in);
         nc = r[7:0] | 8'h01;
         cr = (t == 0) ? r[15:8] : 8'h00;
         v = nc | cr;
         watch(t * STEP + 5, 0, acc, first);
         chk("forwarded", {4'h0, v}, acc);
         chk("defer_lat", 12'h1, 12'(first <= t * STEP + 2));
      end
      $display("test irq_defer done");
      powered = 4'hf;
      @(negedge mclk_in);
      below = 4'h1;
      above = 4'h4;
      watch(DCYC + 8, 2, acc, first);
      chk("fault_ports", 12'h041, acc);
      chk("fault_lat", 12'h1, 12'(first >= DCYC && first <= DCYC + 5));
      below = 4'h0;
      above = 4'h0;
      repeat (6) @(negedge mclk_in);
      chk("recovered", 12'h0, {4'h0, cut_flt, disc_off});
      below = 4'hf;
      repeat (DCYC - 4) @(negedge mclk_in);
      below = 4'h0;
      watch(DCYC + 8, 2, acc, first);
      chk("disc_abort", 12'h0, acc);
      $display("test supervision done");
      wrap_up();
   end
endmodule
